// >>> hw/ext_event_sync.sv
`timescale 1ns/1ps
`include "mon_ovf_defs.svh"

module ext_event_sync
  import mon_ovf_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // pins from the system
  input  wire logic     evt_toggle,
  input  wire logic [2:0] evt_num,
  // one-hot event pulse
  output evt_vec_t      evt_vec
);

  logic       tog_s1_q, tog_s2_q, tog_s3_q;
  logic [2:0] num_s1_q, num_s2_q;
  evt_vec_t   vec_q;
  logic       tog_s1_d, tog_s2_d, tog_s3_d;
  logic [2:0] num_s1_d, num_s2_d;
  evt_vec_t   vec_d;

  // ==========================================================
  // two-flop crossing, edge seen on second and third stage
  always_comb begin
    tog_s1_d = evt_toggle;
    tog_s2_d = tog_s1_q;
    tog_s3_d = tog_s2_q;
    num_s1_d = evt_num;
    num_s2_d = num_s1_q;
    vec_d    = '0;
    // system events use codes 1..6; code 7 is reserved for local triggers
    if ((tog_s2_q != tog_s3_q) && (num_s2_q != `EVT_NONE) && (num_s2_q != `EVT_LOCAL)) begin
      vec_d[num_s2_q] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      num_s1_q <= 3'h0;
      num_s2_q <= 3'h0;
      vec_q    <= '0;
    end else begin
      tog_s1_q <= tog_s1_d;
      tog_s2_q <= tog_s2_d;
      tog_s3_q <= tog_s3_d;
      num_s1_q <= num_s1_d;
      num_s2_q <= num_s2_d;
      vec_q    <= vec_d;
    end
  end

  assign evt_vec = vec_q;

endmodule

// >>> hw/monitor_overflow_linkage.sv
`timescale 1ns/1ps
`include "mon_ovf_defs.svh"

module monitor_overflow_linkage
  import mon_ovf_pkg::*;
#(
  parameter int                     NUM_MON          = 4,
  parameter logic [2*NUM_MON-1:0]   SPACE_MAP        = '0,
  parameter logic [NUM_MON-1:0]     IS_BW            = '0,
  parameter bit                     LINK_SUPPORTED   = 1'b1,
  parameter bit                     CAPT_SUPPORTED   = 1'b1,
  parameter bit                     OCAPT_SUPPORTED  = 1'b1,
  parameter bit                     LONG_SUPPORTED   = 1'b1,
  parameter bit                     LOCAL_SUPPORTED  = 1'b1,
  localparam int                    IW = (NUM_MON > 1) ? $clog2(NUM_MON) : 1
)
(
  // clock and reset
  input  wire logic               CORE_CLK,
  input  wire logic               RESETN,
  // register access, per selected instance
  input  wire logic [IW-1:0]      REG_SEL,
  input  wire logic               CTL_WR,
  input  wire logic [31:0]        CTL_WDATA,
  input  wire logic               CNT_WR,
  input  wire logic               CNT_L_WR,
  output logic [31:0]             CTL_RDATA,
  // local capture trigger write
  input  wire logic               LCAPT_WR,
  input  wire logic [1:0]         LCAPT_SPACE,
  input  wire logic               LCAPT_ALL,
  // external capture event pins
  input  wire logic               EXT_EVT_TOGGLE,
  input  wire logic [2:0]         EXT_EVT_NUM,
  // counting logic side
  input  wire logic [NUM_MON-1:0] OVF,
  input  wire logic [NUM_MON-1:0] OVF_L,
  output logic [NUM_MON-1:0]      FREEZE,
  output logic [NUM_MON-1:0]      FREEZE_L,
  output logic [NUM_MON-1:0]      CAPTURE,
  output logic [NUM_MON-1:0]      CAPTURE_L,
  output logic [NUM_MON-1:0]      CLEAR,
  output logic [NUM_MON-1:0]      OVF_IRQ
);

  // ==========================================================
  // field helpers
  function automatic ctl_s ctl_unpack(input logic [31:0] w, input logic bw);
    ctl_s c;
    c.capt_evt   = w[`CTL_CEVT_MSB:`CTL_CEVT_LSB];
    c.cevnt_ovf  = w[`CTL_CEVNT_BIT];
    c.link_evt   = LINK_SUPPORTED ? w[`CTL_LINK_MSB:`CTL_LINK_LSB] : 3'h0;
    c.capt_ovf   = CAPT_SUPPORTED & OCAPT_SUPPORTED & w[`CTL_CAPT_BIT];
    c.capt_ovf_l = CAPT_SUPPORTED & OCAPT_SUPPORTED & LONG_SUPPORTED & bw & w[`CTL_CAPT_L_BIT];
    c.frz        = w[`CTL_FRZ_BIT];
    c.irq_en     = w[`CTL_IRQ_BIT];
    c.irq_en_l   = LONG_SUPPORTED & bw & w[`CTL_IRQ_L_BIT];
    c.clr_after  = w[`CTL_CLR_BIT];
    return c;
  endfunction

  function automatic logic [31:0] ctl_pack(input ctl_s c, input logic flag);
    logic [31:0] w;
    w = `CTL_RESET_VAL;
    w[`CTL_CEVT_MSB:`CTL_CEVT_LSB] = c.capt_evt;
    w[`CTL_CEVNT_BIT]              = c.cevnt_ovf;
    w[`CTL_LINK_MSB:`CTL_LINK_LSB] = c.link_evt;
    w[`CTL_CAPT_BIT]               = c.capt_ovf;
    w[`CTL_CAPT_L_BIT]             = c.capt_ovf_l;
    w[`CTL_FRZ_BIT]                = c.frz;
    w[`CTL_IRQ_BIT]                = c.irq_en;
    w[`CTL_IRQ_L_BIT]              = c.irq_en_l;
    w[`CTL_CLR_BIT]                = c.clr_after;
    w[`CTL_FLAG_BIT]               = flag;
    return w;
  endfunction

  function automatic logic [1:0] space_of(input int i);
    return SPACE_MAP[2*i +: 2];
  endfunction

  // ==========================================================
  // state
  ctl_s               ctl_q   [NUM_MON];
  ctl_s               ctl_d   [NUM_MON];
  logic [NUM_MON-1:0] flag_q, flag_d;
  logic [NUM_MON-1:0] frz_q, frz_d;
  logic [NUM_MON-1:0] frz_l_q, frz_l_d;
  logic [NUM_MON-1:0] cap_q, cap_d;
  logic [NUM_MON-1:0] cap_l_q, cap_l_d;
  logic [NUM_MON-1:0] clr_q, clr_d;
  logic [NUM_MON-1:0] irq_q, irq_d;
  logic [NUM_MON-1:0] link_pulse;
  evt_vec_t           ev_q    [4];
  evt_vec_t           ev_d    [4];
  evt_vec_t           ext_vec;
  logic [31:0]        rdata_q, rdata_d;

  ext_event_sync u_ext_sync (
    .clk        (CORE_CLK),
    .rst_n      (RESETN),
    .evt_toggle (EXT_EVT_TOGGLE),
    .evt_num    (EXT_EVT_NUM),
    .evt_vec    (ext_vec)
  );

  // ==========================================================
  // per-instance overflow handling
  always_comb begin
    logic sel, linked, hit, hit_l, any, rise, wr_me, flag_wclr, cnt_clr, fire, fire_l;
    logic has_long;
    sel = 1'b0; linked = 1'b0; hit = 1'b0; hit_l = 1'b0; any = 1'b0; rise = 1'b0;
    wr_me = 1'b0; flag_wclr = 1'b0; cnt_clr = 1'b0; fire = 1'b0; fire_l = 1'b0;
    has_long = 1'b0;
    for (int i = 0; i < NUM_MON; i++) begin
      has_long = LONG_SUPPORTED & IS_BW[i];
      wr_me    = (REG_SEL == IW'(i));
      sel    = (ctl_q[i].capt_evt != `EVT_NONE) && ev_q[space_of(i)][ctl_q[i].capt_evt];
      linked = sel & ctl_q[i].cevnt_ovf;
      hit    = OVF[i] | linked;
      hit_l  = OVF_L[i] & has_long;
      any    = hit | hit_l;
      rise   = any & ~flag_q[i];

      ctl_d[i] = ctl_q[i];
      if (CTL_WR && wr_me) begin
        ctl_d[i] = ctl_unpack(CTL_WDATA, IS_BW[i]);
      end

      // clear by control or count write
      flag_wclr = CTL_WR & wr_me & ~CTL_WDATA[`CTL_FLAG_BIT];
      cnt_clr   = wr_me & (CNT_WR | CNT_L_WR);
      flag_d[i] = any | (flag_q[i] & ~(flag_wclr | cnt_clr));

      fire   = rise & hit & ctl_q[i].irq_en;
      fire_l = rise & hit_l & ctl_q[i].irq_en_l;
      irq_d[i] = fire | fire_l;
      link_pulse[i] = LINK_SUPPORTED & (fire | fire_l)
                      & (ctl_q[i].link_evt != `EVT_NONE)
                      & (ctl_q[i].link_evt <= `EVT_LINK_MAX);

      frz_d[i] = (ctl_q[i].frz & hit)
                 | (~CAPT_SUPPORTED & sel & ctl_q[i].frz & ~flag_q[i])
                 | (frz_q[i] & ~(flag_wclr | (wr_me & CNT_WR)));
      frz_l_d[i] = has_long & ((ctl_q[i].frz & (hit_l | linked))
                 | (frz_l_q[i] & ~(flag_wclr | (wr_me & CNT_L_WR))));

      cap_d[i] = CAPT_SUPPORTED & (sel | (hit & ctl_q[i].capt_ovf));
      cap_l_d[i] = CAPT_SUPPORTED & has_long
                   & (sel | ((hit_l | linked) & ctl_q[i].capt_ovf_l));
      clr_d[i] = (cap_d[i] | cap_l_d[i]) & ctl_q[i].clr_after;
    end
  end

  // ==========================================================
  // event distribution, one cycle after the source so chains cannot loop
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      ev_d[s] = ext_vec;
      for (int i = 0; i < NUM_MON; i++) begin
        if (link_pulse[i] && (space_of(i) == 2'(s))) begin
          ev_d[s][ctl_q[i].link_evt] = 1'b1;
        end
      end
      ev_d[s][`EVT_LOCAL] = LOCAL_SUPPORTED & LCAPT_WR
                            & ((LCAPT_SPACE == 2'(s))
                            | (LCAPT_ALL & (LCAPT_SPACE == SPACE_S) & (2'(s) == SPACE_NS)));
    end
  end

  // ==========================================================
  // readback of the selected control register
  always_comb begin
    rdata_d = `CTL_RESET_VAL;
    for (int i = 0; i < NUM_MON; i++) begin
      if (REG_SEL == IW'(i)) begin
        rdata_d = ctl_pack(ctl_q[i], flag_q[i]);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < NUM_MON; i++) begin
        ctl_q[i] <= '0;
      end
      for (int s = 0; s < 4; s++) begin
        ev_q[s] <= '0;
      end
      flag_q  <= '0;
      frz_q   <= '0;
      frz_l_q <= '0;
      cap_q   <= '0;
      cap_l_q <= '0;
      clr_q   <= '0;
      irq_q   <= '0;
      rdata_q <= `CTL_RESET_VAL;
    end else begin
      for (int i = 0; i < NUM_MON; i++) begin
        ctl_q[i] <= ctl_d[i];
      end
      for (int s = 0; s < 4; s++) begin
        ev_q[s] <= ev_d[s];
      end
      flag_q  <= flag_d;
      frz_q   <= frz_d;
      frz_l_q <= frz_l_d;
      cap_q   <= cap_d;
      cap_l_q <= cap_l_d;
      clr_q   <= clr_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  // events have no output port
  assign FREEZE    = frz_q;
  assign FREEZE_L  = frz_l_q;
  assign CAPTURE   = cap_q;
  assign CAPTURE_L = cap_l_q;
  assign CLEAR     = clr_q;
  assign OVF_IRQ   = irq_q;
  assign CTL_RDATA = rdata_q;

endmodule

// >>> shared/mon_ovf_defs.svh
`ifndef MON_OVF_DEFS_SVH
`define MON_OVF_DEFS_SVH

// ==========================================================
// control register field positions
`define CTL_CEVT_LSB     4
`define CTL_CEVT_MSB     6
`define CTL_LINK_LSB     8
`define CTL_LINK_MSB     10
`define CTL_CEVNT_BIT    12
`define CTL_CAPT_L_BIT   13
`define CTL_IRQ_L_BIT    14
`define CTL_CAPT_BIT     23
`define CTL_FRZ_BIT      24
`define CTL_IRQ_BIT      25
`define CTL_FLAG_BIT     26
`define CTL_CLR_BIT      27

// ==========================================================
// reset value and event codes
`define CTL_RESET_VAL    32'h0000_0000
`define EVT_NONE         3'h0
`define EVT_LINK_MAX     3'h6
`define EVT_LOCAL        3'h7

`endif

// >>> shared/mon_ovf_pkg.sv
package mon_ovf_pkg;

  // ==========================================================
  // partition spaces, in address-space order
  typedef enum logic [1:0] {
    SPACE_NS,
    SPACE_S,
    SPACE_ROOT,
    SPACE_REALM
  } space_e;

  // one bit per capture event code 1..7
  typedef logic [7:1] evt_vec_t;

  // ==========================================================
  // per-instance overflow controls
  typedef struct packed {
    logic [2:0] capt_evt;
    logic       cevnt_ovf;
    logic [2:0] link_evt;
    logic       capt_ovf;
    logic       capt_ovf_l;
    logic       frz;
    logic       irq_en;
    logic       irq_en_l;
    logic       clr_after;
  } ctl_s;

endpackage

// >>> test/mol_chk.sv
`timescale 1ns/1ps
// ======
// overflow linkage checks
module mol_chk #(
  parameter int  NUM_MON = 4,
  localparam int IW      = (NUM_MON > 1) ? $clog2(NUM_MON) : 1
)(
  // clock and reset
  input wire logic               CORE_CLK,
  input wire logic               RESETN,
  // register side
  input wire logic [IW-1:0]      REG_SEL,
  input wire logic               CTL_WR,
  input wire logic [31:0]        CTL_WDATA,
  input wire logic               CNT_WR,
  input wire logic               CNT_L_WR,
  input wire logic [31:0]        CTL_RDATA,
  // counting side
  input wire logic [NUM_MON-1:0] OVF,
  input wire logic [NUM_MON-1:0] OVF_L,
  input wire logic [NUM_MON-1:0] FREEZE,
  input wire logic [NUM_MON-1:0] FREEZE_L,
  input wire logic [NUM_MON-1:0] CAPTURE,
  input wire logic [NUM_MON-1:0] CAPTURE_L,
  input wire logic [NUM_MON-1:0] CLEAR,
  input wire logic [NUM_MON-1:0] OVF_IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  a_irq_single: assert property ((OVF_IRQ & $past(OVF_IRQ)) == '0)
    else $error("interrupt pulse lasted two cycles");
  // a long-only capture also zeroes the count
  a_clear_capt: assert property ((CLEAR & ~(CAPTURE | CAPTURE_L)) == '0)
    else $error("clear without capture");
  a_freeze_release: assert property (($past(FREEZE) & ~FREEZE) != '0
    |-> $past(CNT_WR || CTL_WR) || $past(CNT_WR || CTL_WR, 2))
    else $error("freeze dropped without a write");
  a_long_release: assert property (($past(FREEZE_L) & ~FREEZE_L) != '0
    |-> $past(CNT_L_WR || CTL_WR) || $past(CNT_L_WR || CTL_WR, 2))
    else $error("long freeze dropped without a write");
  a_cnt_unfreeze: assert property (CNT_WR && REG_SEL == '0 && !OVF[0]
    |-> ##[1:2] !FREEZE[0])
    else $error("count write left freeze set");
  // latency of readback is two cycles, so wait three
  a_ctl_readback: assert property (CTL_WR ##1 (!CTL_WR && $stable(REG_SEL))[*3]
    |-> CTL_RDATA[25:24] == $past(CTL_WDATA[25:24], 3))
    else $error("control readback wrong");
  a_flag_clear: assert property (CTL_WR && !CTL_WDATA[26] && (OVF | OVF_L) == '0
    ##1 (!CTL_WR && $stable(REG_SEL) && (OVF | OVF_L) == '0 && CAPTURE == '0)[*3]
    |-> !CTL_RDATA[26])
    else $error("flag not cleared by control write");
  a_flag_on_irq: assert property (OVF_IRQ[REG_SEL] && !CTL_WR && !CNT_WR && !CNT_L_WR
    ##1 (!CTL_WR && !CNT_WR && !CNT_L_WR && $stable(REG_SEL))[*2] |-> CTL_RDATA[26])
    else $error("interrupt without overflow flag");
  c_irq: cover property (OVF_IRQ != '0);
  c_long: cover property (FREEZE_L != '0);
  c_clear: cover property (CLEAR != '0);
endmodule

bind monitor_overflow_linkage mol_chk #(.NUM_MON(NUM_MON)) chk_u (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_SEL(REG_SEL), .CTL_WR(CTL_WR),
  .CTL_WDATA(CTL_WDATA), .CNT_WR(CNT_WR), .CNT_L_WR(CNT_L_WR), .CTL_RDATA(CTL_RDATA),
  .OVF(OVF), .OVF_L(OVF_L), .FREEZE(FREEZE), .FREEZE_L(FREEZE_L), .CAPTURE(CAPTURE),
  .CAPTURE_L(CAPTURE_L), .CLEAR(CLEAR), .OVF_IRQ(OVF_IRQ)
);

// >>> test/monitor_overflow_linkage_bench.sv
`timescale 1ns/1ps
// ======
// overflow linkage bench
module monitor_overflow_linkage_bench;
  logic        CORE_CLK = 0, RESETN = 0, CTL_WR = 0, CNT_WR = 0, CNT_L_WR = 0;
  logic        LCAPT_WR = 0, LCAPT_ALL = 0, EXT_EVT_TOGGLE = 0;
  logic [1:0]  REG_SEL = 0, LCAPT_SPACE = 0;
  logic [2:0]  EXT_EVT_NUM = 0;
  logic [31:0] CTL_WDATA = 0, CTL_RDATA;
  logic [3:0]  OVF = 0, OVF_L = 0, FREEZE, FREEZE_L, CAPTURE, CAPTURE_L, CLEAR, OVF_IRQ;
  logic [3:0]  cap_s = 0, clr_s = 0, irq_s = 0, capl_s = 0;
  // space, all bit, expected capture set
  logic [6:0]  lt [5] = '{7'h03, 7'h24, 7'h37, 7'h40, 7'h68};
  int          n_errors = 0, checked = 0;
  initial forever #4 CORE_CLK = ~CORE_CLK;
  // pulses are short, so keep a sticky copy
  always @(posedge CORE_CLK) begin
    cap_s <= cap_s | CAPTURE;
    clr_s <= clr_s | CLEAR;
    irq_s <= irq_s | OVF_IRQ;
    capl_s <= capl_s | CAPTURE_L;
  end
  // instances 0,1 non-secure, 2 secure, 3 realm; 0 is bandwidth
  monitor_overflow_linkage #(.SPACE_MAP(8'hD0), .IS_BW(4'h1)) dut_u (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_SEL(REG_SEL), .CTL_WR(CTL_WR),
    .CTL_WDATA(CTL_WDATA), .CNT_WR(CNT_WR), .CNT_L_WR(CNT_L_WR), .CTL_RDATA(CTL_RDATA),
    .LCAPT_WR(LCAPT_WR), .LCAPT_SPACE(LCAPT_SPACE), .LCAPT_ALL(LCAPT_ALL),
    .EXT_EVT_TOGGLE(EXT_EVT_TOGGLE), .EXT_EVT_NUM(EXT_EVT_NUM), .OVF(OVF), .OVF_L(OVF_L),
    .FREEZE(FREEZE), .FREEZE_L(FREEZE_L), .CAPTURE(CAPTURE), .CAPTURE_L(CAPTURE_L),
    .CLEAR(CLEAR), .OVF_IRQ(OVF_IRQ));
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_ctl(input logic [1:0] s, input logic [31:0] d);
    REG_SEL = s;
    CTL_WDATA = d;
    CTL_WR = 1;
    tick(1);
    CTL_WR = 0;
    tick(1);
  endtask
  task automatic cnt(input logic [1:0] s, input bit l);
    REG_SEL = s;
    CNT_WR = !l;
    CNT_L_WR = l;
    tick(1);
    CNT_WR = 0;
    CNT_L_WR = 0;
    tick(3);
  endtask
  task automatic ovf(input logic [3:0] v);
    irq_s = 0;
    cap_s = 0;
    clr_s = 0;
    capl_s = 0;
    OVF = v;
    tick(1);
    OVF = 0;
    tick(4);
  endtask
  task automatic rst();
    RESETN = 0;
    tick(2);
    RESETN = 1;
    tick(4);
  endtask
  function automatic logic [31:0] cw(input logic [2:0] ce, lk, input logic cv, fz, ie);
    cw = 32'h0000_0000;
    cw[6:4] = ce;
    cw[10:8] = lk;
    cw[12] = cv;
    cw[24] = fz;
    cw[25] = ie;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    tick(20);
    RESETN = 1;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      REG_SEL = 2'(i);
      tick(2);
      chk("ctl reset", 32'h0000_0000, CTL_RDATA);
    end
    $display("test reset done");
    wr_ctl(3, cw(0, 0, 0, 0, 1));
    wr_ctl(0, cw(0, 0, 0, 1, 1) | 32'h0880_0000);
    ovf(4'h9);
    chk("irq", 4'h9, irq_s);
    chk("capture", 4'h1, cap_s);
    chk("clear", 4'h1, clr_s);
    chk("freeze", 4'h1, FREEZE);
    chk("flag", 1'h1, CTL_RDATA[26]);
    ovf(4'h1);
    chk("irq repeat", 4'h0, irq_s);
    cnt(0, 0);
    chk("freeze after count write", 4'h0, FREEZE);
    chk("flag after count write", 1'h0, CTL_RDATA[26]);
    wr_ctl(3, cw(0, 0, 0, 0, 1));
    tick(2);
    chk("flag after ctl write", 1'h0, CTL_RDATA[26]);
    $display("test overflow done");
    rst();
    wr_ctl(0, cw(3, 0, 1, 1, 0));
    wr_ctl(2, cw(3, 0, 1, 1, 0));
    wr_ctl(1, cw(0, 3, 0, 0, 0));
    ovf(4'h2);
    chk("link without irq", 4'h0, FREEZE);
    wr_ctl(1, cw(0, 3, 0, 0, 1));
    ovf(4'h2);
    chk("linked freeze", 4'h1, FREEZE);
    chk("linked long freeze", 4'h1, FREEZE_L);
    chk("linked irq", 4'h2, irq_s);
    chk("linked long capture", 4'h1, capl_s);
    cnt(0, 0);
    chk("long stays", 4'h1, FREEZE_L);
    cnt(0, 1);
    chk("long released", 4'h0, FREEZE_L);
    // long overflow links only through the long irq enable
    wr_ctl(1, cw(3, 0, 1, 1, 0));
    wr_ctl(0, cw(0, 3, 0, 0, 0) | 32'h0000_4000);
    irq_s = 0;
    cap_s = 0;
    capl_s = 0;
    OVF_L = 4'h1;
    tick(1);
    OVF_L = 4'h0;
    tick(4);
    chk("long linked irq", 4'h1, irq_s);
    chk("long linked freeze", 4'h2, FREEZE);
    chk("long linked capture", 4'h2, cap_s);
    chk("long capture bw only", 4'h0, capl_s);
    $display("test linkage done");
    rst();
    for (int i = 0; i < 4; i++)
      wr_ctl(2'(i), cw(7, 0, 0, 0, 0));
    for (int i = 0; i < 5; i++) begin
      cap_s = 0;
      {LCAPT_SPACE, LCAPT_ALL} = lt[i][6:4];
      LCAPT_WR = 1;
      tick(1);
      LCAPT_WR = 0;
      tick(4);
      chk("local capture", lt[i][3:0], cap_s);
    end
    $display("test local done");
    for (int i = 0; i < 4; i++)
      wr_ctl(2'(i), cw(i < 3 ? 3'h2 : 3'h0, 0, 0, 0, 0));
    cap_s = 0;
    EXT_EVT_NUM = 3'h2;
    tick(3);
    EXT_EVT_TOGGLE = 1;
    tick(8);
    chk("external capture", 4'h7, cap_s);
    $display("test external done");
    final_report();
  end
endmodule
